// ---- hdl/flash_host_pkg.sv ----
// constants, command bytes, operation codes and states of the flash host controller
// assumes a 100 MHz mclk and a byte-wide asynchronous flash on the far side
// Notes on behaviour
// - host holds reset/power-down low at least 100 ns for power-down.
// - command writes need write strobe and chip select; first rising strobe captures.
// - erase is 20H then D0H, both inside the target block.
// - block lock is 60H then 01H inside the target block.
// - master lock is 60H then F1H at any address.
package flash_host_pkg;

    localparam int CLK_PERIOD_NS    = 10;
    localparam int T_PD_MIN_NS      = 100;
    localparam int T_WRITE_PULSE_NS = 60;
    localparam int T_STROBE_GAP_NS  = 30;
    localparam int T_ACCESS_NS      = 150;
    localparam int T_WAKE_NS        = 1000;

    function automatic int ns_to_cycles(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int PD_CYC   = ns_to_cycles(T_PD_MIN_NS);
    localparam int WP_CYC   = ns_to_cycles(T_WRITE_PULSE_NS);
    localparam int GAP_CYC  = ns_to_cycles(T_STROBE_GAP_NS);
    localparam int ACC_CYC  = ns_to_cycles(T_ACCESS_NS);
    localparam int WAKE_CYC = ns_to_cycles(T_WAKE_NS);
    localparam int SYNC_CYC = 2;

    localparam logic [3:0] REG_CMD    = 4'h0;
    localparam logic [3:0] REG_ADDR   = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;
    localparam logic [3:0] REG_CONFIG = 4'hC;

    localparam int CMD_OP_LSB      = 0;
    localparam int CMD_DATA_LSB    = 8;
    localparam int ST_BUSY_BIT     = 0;
    localparam int ST_RB_BIT       = 1;
    localparam int ST_REFUSED_BIT  = 2;
    localparam int ST_STATMODE_BIT = 3;
    localparam int ST_DATA_LSB     = 8;
    localparam int CFG_VHH_BIT     = 0;
    localparam int CFG_VPP_BIT     = 1;

    localparam logic [31:0] CMD_RESET    = 32'h0000_0000;
    localparam logic [31:0] ADDR_RESET   = 32'h0000_0000;
    localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;

    localparam logic [7:0] CB_READ_ARRAY  = 8'hFF;
    localparam logic [7:0] CB_READ_ID     = 8'h90;
    localparam logic [7:0] CB_READ_STATUS = 8'h70;
    localparam logic [7:0] CB_CLEAR_STAT  = 8'h50;
    localparam logic [7:0] CB_ERASE_SETUP = 8'h20;
    localparam logic [7:0] CB_CONFIRM     = 8'hD0;
    localparam logic [7:0] CB_PROG_SETUP  = 8'h40;
    localparam logic [7:0] CB_SUSPEND     = 8'hB0;
    localparam logic [7:0] CB_LOCK_SETUP  = 8'h60;
    localparam logic [7:0] CB_BLOCK_LOCK  = 8'h01;
    localparam logic [7:0] CB_MASTER_LOCK = 8'hF1;

    typedef enum logic [3:0] {
        OP_READ_ARRAY  = 4'h0, OP_READ_ID     = 4'h1, OP_READ_STATUS = 4'h2,
        OP_CLEAR_STAT  = 4'h3, OP_ERASE       = 4'h4, OP_BYTE_WRITE  = 4'h5,
        OP_SUSPEND     = 4'h6, OP_RESUME      = 4'h7, OP_BLOCK_LOCK  = 4'h8,
        OP_MASTER_LOCK = 4'h9, OP_CLEAR_LOCKS = 4'hA, OP_BUS_READ    = 4'hB,
        OP_POWER_DOWN  = 4'hC
    } op_t;

    typedef enum logic [6:0] {
        S_IDLE   = 7'h01, S_STROBE = 7'h02, S_HOLD    = 7'h04, S_GAP = 7'h08,
        S_READ   = 7'h10, S_PD_LOW = 7'h20, S_PD_WAKE = 7'h40
    } state_t;

    function automatic logic op_valid(input logic [3:0] op);
        return op <= 4'hC;
    endfunction

    function automatic logic two_cycle(input op_t op);
        return op inside {OP_ERASE, OP_BYTE_WRITE, OP_BLOCK_LOCK, OP_MASTER_LOCK,
                          OP_CLEAR_LOCKS};
    endfunction

    function automatic logic [7:0] first_byte(input op_t op);
        case (op)
            OP_READ_ID:     return CB_READ_ID;
            OP_READ_STATUS: return CB_READ_STATUS;
            OP_CLEAR_STAT:  return CB_CLEAR_STAT;
            OP_ERASE:       return CB_ERASE_SETUP;
            OP_BYTE_WRITE:  return CB_PROG_SETUP;
            OP_SUSPEND:     return CB_SUSPEND;
            OP_RESUME:      return CB_CONFIRM;
            OP_BLOCK_LOCK, OP_MASTER_LOCK, OP_CLEAR_LOCKS: return CB_LOCK_SETUP;
            default:        return CB_READ_ARRAY;
        endcase
    endfunction

    function automatic logic [7:0] second_byte(input op_t op, input logic [7:0] wd);
        case (op)
            OP_BYTE_WRITE:  return wd;
            OP_BLOCK_LOCK:  return CB_BLOCK_LOCK;
            OP_MASTER_LOCK: return CB_MASTER_LOCK;
            default:        return CB_CONFIRM;
        endcase
    endfunction

    // reads after these ops return flash status
    function automatic logic leaves_status(input op_t op);
        return op inside {OP_READ_STATUS, OP_ERASE, OP_BYTE_WRITE, OP_SUSPEND, OP_RESUME,
                          OP_BLOCK_LOCK, OP_MASTER_LOCK, OP_CLEAR_LOCKS};
    endfunction

endpackage

// ---- hdl/flash_pin_sync.sv ----
// two-flop synchroniser for flash pins entering the mclk domain
// assumes inputs are asynchronous to mclk
`timescale 1ns/1ps
`default_nettype none
module flash_pin_sync #(
    parameter int W = 9
) (
    input  wire logic         mclk,
    input  wire logic         rst,
    input  wire logic [W-1:0] pin,
    output logic      [W-1:0] pin_sync
);
    logic [W-1:0] stage1;
    logic [W-1:0] next_stage1;
    logic [W-1:0] next_pin_sync;

    always_comb begin
        next_stage1   = pin;
        next_pin_sync = stage1;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            stage1   <= '0;
            pin_sync <= '0;
        end else begin
            stage1   <= next_stage1;
            pin_sync <= next_pin_sync;
        end
    end
endmodule // flash_pin_sync
`default_nettype wire

// ---- hdl/flash_host_ctrl.sv ----
// host controller driving a byte-wide flash through its pins, wishbone register slave
// assumes one 100 MHz clock, synchronous reset, bench resolves the data line wire
//
// Implementation choices: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module flash_host_ctrl #(
    parameter int ADDR_W   = 20,
    parameter int PD_CNT   = flash_host_pkg::PD_CYC,
    parameter int WAKE_CNT = flash_host_pkg::WAKE_CYC
) (
    input  wire logic              mclk,
    input  wire logic              rst,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [3:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    output logic      [ADDR_W-1:0] flash_addr,
    output logic                   chip_select_n,
    output logic                   output_enable_n,
    output logic                   write_strobe_n,
    output logic                   reset_powerdown_n,
    output logic                   vhh_select,
    output logic                   vpp_enable,
    input  wire logic [7:0]        data_lines_in,
    output logic      [7:0]        data_lines_out,
    output logic                   data_lines_oe,
    input  wire logic              ready_busy_out
);
    import flash_host_pkg::*;

    if (ADDR_W < 17 || ADDR_W > 32 || PD_CNT < PD_CYC || PD_CNT > 65536
        || WAKE_CNT < 1 || WAKE_CNT > 65535) begin : g_chk
        $error("flash_host_ctrl: unsupported parameter values");
    end

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (sel[i]) r[8*i +: 8] = nw[8*i +: 8];
        return r;
    endfunction

    logic [8:0]  pins_sync;
    logic [7:0]  data_sync;
    logic        rb_sync;

    flash_pin_sync #(.W(9)) u_sync (
        .mclk     (mclk),
        .rst      (rst),
        .pin      ({ready_busy_out, data_lines_in}),
        .pin_sync (pins_sync)
    );
    assign data_sync = pins_sync[7:0];
    assign rb_sync   = pins_sync[8];

    // bus group
    logic [31:0] cmd_reg, addr_reg, cfg_reg;
    logic        refused, launch;
    logic [31:0] next_cmd_reg, next_addr_reg, next_cfg_reg, next_dat_o;
    logic        next_refused, next_launch, next_ack;
    // fsm group
    state_t      state, next_state;
    op_t         op_r, next_op_r;
    logic [15:0] cnt, next_cnt;
    logic        phase, next_phase, status_mode, next_status_mode;
    logic [7:0]  rdata, next_rdata, next_dout;
    logic [ADDR_W-1:0] next_faddr;
    logic        next_ce_n, next_oe_n, next_we_n, next_rp_n, next_doe;
    logic        busy, wr_hit, op_bad, op_blocked;

    assign busy = (state != S_IDLE) || launch;

    always_comb begin
        next_cmd_reg  = cmd_reg;
        next_addr_reg = addr_reg;
        next_cfg_reg  = cfg_reg;
        next_refused  = refused;
        next_launch   = 1'b0;
        next_ack      = wb_cyc_i && wb_stb_i && !wb_ack_o;
        next_dat_o    = 32'h0000_0000;
        wr_hit        = next_ack && wb_we_i;
        op_bad        = !op_valid(wb_dat_i[CMD_OP_LSB +: 4]);
        // read array held back while flash runs unsuspended
        op_blocked    = (wb_dat_i[CMD_OP_LSB +: 4] == OP_READ_ARRAY) && !rb_sync;
        if (wr_hit) begin
            case (wb_adr_i)
                REG_CMD: begin
                    if (wb_sel_i[0]) begin
                        // reserved codes never reach the flash
                        if (busy || op_bad || op_blocked) begin
                            next_refused = 1'b1;
                        end else begin
                            next_cmd_reg = merge(cmd_reg, wb_dat_i, wb_sel_i);
                            next_launch  = 1'b1;
                        end
                    end
                end
                REG_ADDR:   next_addr_reg = merge(addr_reg, wb_dat_i, wb_sel_i);
                REG_CONFIG: next_cfg_reg  = merge(cfg_reg, wb_dat_i, wb_sel_i);
                REG_STATUS: begin
                    if (wb_sel_i[0] && wb_dat_i[ST_REFUSED_BIT]) next_refused = 1'b0;
                end
                default: ;
            endcase
        end else if (next_ack) begin
            case (wb_adr_i)
                REG_CMD:    next_dat_o = cmd_reg;
                REG_ADDR:   next_dat_o = addr_reg;
                REG_CONFIG: next_dat_o = cfg_reg;
                REG_STATUS: begin
                    next_dat_o[ST_BUSY_BIT]              = busy;
                    next_dat_o[ST_RB_BIT]                = rb_sync;
                    next_dat_o[ST_REFUSED_BIT]           = refused;
                    next_dat_o[ST_STATMODE_BIT]          = status_mode;
                    next_dat_o[ST_DATA_LSB +: 8]         = rdata;
                end
                default: next_dat_o = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            cmd_reg    <= CMD_RESET;
            addr_reg   <= ADDR_RESET;
            cfg_reg    <= CONFIG_RESET;
            refused    <= 1'b0;
            launch     <= 1'b0;
            wb_ack_o   <= 1'b0;
            wb_dat_o   <= 32'h0000_0000;
            vhh_select <= 1'b0;
            vpp_enable <= 1'b0;
        end else begin
            cmd_reg    <= next_cmd_reg;
            addr_reg   <= next_addr_reg;
            cfg_reg    <= next_cfg_reg;
            refused    <= next_refused;
            launch     <= next_launch;
            wb_ack_o   <= next_ack;
            wb_dat_o   <= next_dat_o;
            // override level requested by software for locked blocks
            vhh_select <= next_cfg_reg[CFG_VHH_BIT];
            // program supply only raised on request
            vpp_enable <= next_cfg_reg[CFG_VPP_BIT];
        end
    end

    always_comb begin
        next_state       = state;
        next_op_r        = op_r;
        next_cnt         = (cnt != 16'h0000) ? cnt - 16'h0001 : cnt;
        next_phase       = phase;
        next_status_mode = status_mode;
        next_rdata       = rdata;
        next_dout        = data_lines_out;
        next_doe         = data_lines_oe;
        next_faddr       = flash_addr;
        next_ce_n        = chip_select_n;
        next_oe_n        = output_enable_n;
        next_we_n        = write_strobe_n;
        next_rp_n        = reset_powerdown_n;
        case (state)
            S_IDLE: begin
                if (launch) begin
                    next_op_r  = op_t'(cmd_reg[CMD_OP_LSB +: 4]);
                    next_faddr = addr_reg[ADDR_W-1:0];
                    next_phase = 1'b0;
                    if (next_op_r == OP_POWER_DOWN) begin
                        next_rp_n  = 1'b0;
                        next_cnt   = 16'(PD_CNT - 1);
                        next_state = S_PD_LOW;
                    end else if (next_op_r == OP_BUS_READ) begin
                        next_ce_n  = 1'b0;
                        next_oe_n  = 1'b0;
                        next_cnt   = 16'(ACC_CYC + SYNC_CYC - 1);
                        next_state = S_READ;
                    end else begin
                        next_ce_n  = 1'b0;
                        next_we_n  = 1'b0;
                        next_doe   = 1'b1;
                        next_dout  = first_byte(next_op_r);
                        next_cnt   = 16'(WP_CYC - 1);
                        next_state = S_STROBE;
                    end
                end
            end
            S_STROBE: begin
                if (cnt == 16'h0000) begin
                    // write strobe rises first, captures the byte
                    next_we_n  = 1'b1;
                    next_cnt   = 16'(GAP_CYC - 1);
                    next_state = S_HOLD;
                end
            end
            S_HOLD: begin
                if (cnt == 16'h0000) begin
                    next_ce_n = 1'b1;
                    next_doe  = 1'b0;
                    next_cnt  = 16'(GAP_CYC - 1);
                    if (two_cycle(op_r) && !phase) begin
                        next_phase = 1'b1;
                        next_state = S_GAP;
                    end else begin
                        // status output after erase or program
                        next_status_mode = leaves_status(op_r) ||
                                           (status_mode && op_r == OP_CLEAR_STAT);
                        next_state       = S_IDLE;
                    end
                end
            end
            S_GAP: begin
                if (cnt == 16'h0000) begin
                    next_ce_n  = 1'b0;
                    next_we_n  = 1'b0;
                    next_doe   = 1'b1;
                    next_dout  = second_byte(op_r, cmd_reg[CMD_DATA_LSB +: 8]);
                    next_cnt   = 16'(WP_CYC - 1);
                    next_state = S_STROBE;
                end
            end
            S_READ: begin
                if (cnt == 16'h0000) begin
                    next_rdata = data_sync;
                    next_ce_n  = 1'b1;
                    next_oe_n  = 1'b1;
                    next_state = S_IDLE;
                end
            end
            S_PD_LOW: begin
                if (cnt == 16'h0000) begin
                    next_rp_n  = 1'b1;
                    next_cnt   = 16'(WAKE_CNT - 1);
                    next_state = S_PD_WAKE;
                end
            end
            S_PD_WAKE: begin
                if (cnt == 16'h0000) begin
                    // flash back in read array mode
                    next_status_mode = 1'b0;
                    next_state       = S_IDLE;
                end
            end
            default: next_state = S_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state             <= S_IDLE;
            op_r              <= OP_READ_ARRAY;
            cnt               <= 16'h0000;
            phase             <= 1'b0;
            status_mode       <= 1'b0;
            rdata             <= 8'h00;
            data_lines_out    <= 8'h00;
            data_lines_oe     <= 1'b0;
            flash_addr        <= '0;
            chip_select_n     <= 1'b1;
            output_enable_n   <= 1'b1;
            write_strobe_n    <= 1'b1;
            reset_powerdown_n <= 1'b1;
        end else begin
            state             <= next_state;
            op_r              <= next_op_r;
            cnt               <= next_cnt;
            phase             <= next_phase;
            status_mode       <= next_status_mode;
            rdata             <= next_rdata;
            data_lines_out    <= next_dout;
            data_lines_oe     <= next_doe;
            flash_addr        <= next_faddr;
            chip_select_n     <= next_ce_n;
            output_enable_n   <= next_oe_n;
            write_strobe_n    <= next_we_n;
            reset_powerdown_n <= next_rp_n;
        end
    end

    logic [15:0] pd_low_cnt;
    always_ff @(posedge mclk) begin
        if (rst || reset_powerdown_n) pd_low_cnt <= 16'h0000;
        else if (pd_low_cnt != 16'hFFFF) pd_low_cnt <= pd_low_cnt + 16'h0001;
    end

    a_pd_min_width: assert property (@(posedge mclk) disable iff (rst)
        $rose(reset_powerdown_n) |-> $past(pd_low_cnt) >= 16'(PD_CNT - 1))
        else $error("power-down pulse too short");
    a_strobe_in_select: assert property (@(posedge mclk) disable iff (rst)
        !write_strobe_n |-> !chip_select_n && data_lines_oe && output_enable_n)
        else $error("write strobe outside chip select");
    a_strobe_rises_first: assert property (@(posedge mclk) disable iff (rst)
        $rose(write_strobe_n) |-> !chip_select_n ##1 data_lines_oe && $stable(data_lines_out))
        else $error("chip select rose before write strobe");
    a_erase_confirm_byte: assert property (@(posedge mclk) disable iff (rst)
        $fell(write_strobe_n) && phase && op_r == OP_ERASE
        |-> data_lines_out == CB_CONFIRM && flash_addr == $past(flash_addr, 3))
        else $error("erase confirm byte or address wrong");
    a_block_lock_pair: assert property (@(posedge mclk) disable iff (rst)
        $fell(write_strobe_n) && phase && op_r == OP_BLOCK_LOCK
        |-> data_lines_out == CB_BLOCK_LOCK && flash_addr == addr_reg[ADDR_W-1:0])
        else $error("block lock confirm wrong");
    a_master_lock_pair: assert property (@(posedge mclk) disable iff (rst)
        $fell(write_strobe_n) && op_r == OP_MASTER_LOCK
        |-> data_lines_out == (phase ? CB_MASTER_LOCK : CB_LOCK_SETUP))
        else $error("master lock sequence wrong");
endmodule // flash_host_ctrl
`default_nettype wire

// ---- test/flash_dev_model.sv ----
// behavioural byte-wide flash answering the host controller pins
// assumes the bench resolves the shared data lines from both drivers
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model #(
    parameter int         OP_NS = 3000,
    parameter logic [7:0] MAKER = 8'h5E,
    parameter logic [7:0] PART  = 8'h3D
) (
    input  wire logic [19:0] addr,
    input  wire logic        chip_select_n,
    input  wire logic        output_enable_n,
    input  wire logic        write_strobe_n,
    input  wire logic        reset_powerdown_n,
    input  wire logic        vhh_select,
    input  wire logic        vpp_enable,
    input  wire logic [7:0]  din,
    output logic      [7:0]  dout,
    output logic             ready_busy_out
);
    logic [7:0]  sr = 8'h00, pend = 8'h00, val;
    logic [15:0] lock = 16'h0000;
    logic [1:0]  mode = 2'h0;
    logic        master = 1'b0, run = 1'b0, susp = 1'b0, abort = 1'b0;
    int          left = 0;
    always #10 if (run && !susp) left = left - 1;
    always #10 if (run && left < 0) run = 1'b0;
    assign ready_busy_out = !((run && !susp) || abort);
    always @(reset_powerdown_n) begin
        abort = !reset_powerdown_n && run;
        {run, susp, pend, mode, sr} = '0;
    end
    task automatic start(input logic ok, input logic [7:0] e);
        if (!vpp_enable) sr = sr | 8'h08 | e;
        else if (!ok) sr = sr | 8'h02 | e;
        else {run, left} = {1'b1, OP_NS / 10};
    endtask
    task automatic cmd(input logic [7:0] b, input logic [19:0] a);
        if (pend != 8'h00) begin
            mode = 2'h2;
            if (pend == 8'h20 && b != 8'hD0) sr = sr | 8'h30;
            else if (pend != 8'h60) start(!lock[a[19:16]] || vhh_select, pend == 8'h20 ? 8'h20 : 8'h10);
            else if (b == 8'hF1) start(vhh_select, 8'h10);
            else if (b == 8'h01 || b == 8'hD0) start(!master || vhh_select, 8'h10);
            else sr = sr | 8'h30;
            if (run && pend == 8'h60) master = master | (b == 8'hF1);
            if (run && pend == 8'h60 && b == 8'h01) lock[a[19:16]] = 1'b1;
            if (run && pend == 8'h60 && b == 8'hD0) lock = 16'h0000;
            pend = 8'h00;
        end else case (b)
            8'hFF: if (!run || susp) mode = 2'h0;
            8'h90: mode = 2'h1;
            8'h70: mode = 2'h2;
            8'h50: sr = sr & 8'hC5;
            8'h20, 8'h40, 8'h10, 8'h60: pend = b;
            8'hB0: {susp, mode} = {run, 2'h2};
            8'hD0: {susp, mode} = {1'b0, 2'h2};
            default: ;
        endcase
    endtask
    always @(posedge write_strobe_n or posedge chip_select_n)
        if (reset_powerdown_n && (write_strobe_n ^ chip_select_n)) cmd(din, addr);
    always_comb begin
        val = {!(run && !susp), susp, sr[5:0]};
        if (mode == 2'h0) val = addr[7:0] ^ 8'h3C;
        if (mode == 2'h1) val = addr[1] ? {7'h00, addr[0] ? master : lock[addr[19:16]]}
                                        : (addr[0] ? PART : MAKER);
    end
    // lines drive the inverted value unless selected, enabled and out of power-down
    assign dout = (!chip_select_n && !output_enable_n && reset_powerdown_n) ? val : ~val;
endmodule // flash_dev_model
`default_nettype wire

// ---- test/flash_bus_mode_and_command_decoder_test.sv ----
// self-checking bench: host controller against the behavioural flash
// assumes flash_host_pkg and the flash model are compiled first
`timescale 1ns/1ps
`default_nettype none
module flash_bus_mode_and_command_decoder_test;
    import flash_host_pkg::*;
    logic        mclk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [3:0]  adr = 4'h0, sel = 4'hF;
    logic [31:0] dat = 32'h0, q, dat_o;
    logic        ack, csn, oen, wen, rpn, vhh, vpp, doe, rb;
    logic [19:0] fa;
    logic [7:0]  dout, fq, din;
    int          err_total = 0, n_compared = 0;
    // cfg, op, data, command address, read address, expected byte
    logic [63:0] rows [19] = '{64'h2100_00000_00000_5E, 64'h2100_00000_00001_3D,
        64'h2000_00000_12345_79, 64'h2800_30000_00000_80, 64'h2100_00000_30002_01,
        64'h2400_30000_00000_A2, 64'h2300_00000_00000_80, 64'h3400_30010_00000_80,
        64'h2A00_00000_00000_80, 64'h2100_00000_30002_00, 64'h05AA_00100_00000_98,
        64'h2300_00000_00000_80, 64'h2900_00000_00000_92, 64'h3300_00000_00000_80,
        64'h3900_00000_00000_80, 64'h2800_50000_00000_92, 64'h3300_00000_00000_80,
        64'h2200_00000_00007_80, 64'h255A_00200_00000_80};
    initial forever #5 mclk = ~mclk;
    assign din = doe ? dout : fq;
    flash_host_ctrl #(.WAKE_CNT(2)) DUT (.mclk(mclk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .flash_addr(fa), .chip_select_n(csn), .output_enable_n(oen),
        .write_strobe_n(wen), .reset_powerdown_n(rpn), .vhh_select(vhh), .vpp_enable(vpp),
        .data_lines_in(din), .data_lines_out(dout), .data_lines_oe(doe), .ready_busy_out(rb));
    flash_dev_model flash (.addr(fa), .chip_select_n(csn), .output_enable_n(oen),
        .write_strobe_n(wen), .reset_powerdown_n(rpn), .vhh_select(vhh), .vpp_enable(vpp),
        .din(din), .dout(fq), .ready_busy_out(rb));
    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) err_total++;
        if (s !== e) $display("wrong value %s expected %h seen %h", nm, e, s);
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
        for (n = 0; n <= 50; n++) begin
            @(posedge mclk);
            if (ack === 1'b1) break;
        end
        if (n > 50) err_total++;
        if (n > 50) test_done;
        q = dat_o;
        {cyc, stb} <= 2'b00;
    endtask
    // poll until controller idle and, if full, flash ready
    task automatic issue(input logic [3:0] o, input logic [7:0] d, input logic full);
        int n;
        wb(1'b1, REG_CMD, {16'h0000, d, 4'h0, o});
        for (n = 0; n < 400; n++) begin
            wb(1'b0, REG_STATUS, 32'h0);
            if (q[0] === 1'b0 && (q[1] === 1'b1 || !full)) return;
        end
        err_total++;
        test_done;
    endtask
    initial begin
        int n;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        wb(1'b0, REG_CONFIG, 32'h0);
        chk("config reset", q, CONFIG_RESET);
        wb(1'b0, 4'h2, 32'h0);
        chk("unmapped read", q, 32'h0);
        foreach (rows[i]) begin
            wb(1'b1, REG_CONFIG, {28'h0, rows[i][63:60]});
            wb(1'b1, REG_ADDR, {12'h000, rows[i][47:28]});
            issue(rows[i][59:56], rows[i][55:48], 1'b1);
            wb(1'b1, REG_ADDR, {12'h000, rows[i][27:8]});
            issue(OP_BUS_READ, 8'h00, 1'b1);
            chk("flash byte", {24'h0, q[15:8]}, {24'h0, rows[i][7:0]});
        end
        issue(4'hE, 8'h00, 1'b1);
        chk("reserved refused", {31'h0, q[2]}, 32'h1);
        wb(1'b1, REG_STATUS, 32'h4);
        wb(1'b1, REG_ADDR, 32'h60000);
        issue(OP_ERASE, 8'h00, 1'b0);
        chk("busy after confirm", {31'h0, q[1]}, 32'h0);
        issue(OP_READ_ARRAY, 8'h00, 1'b0);
        chk("array while busy", {31'h0, q[2]}, 32'h1);
        issue(OP_SUSPEND, 8'h00, 1'b1);
        issue(OP_BUS_READ, 8'h00, 1'b1);
        chk("suspended status", {24'h0, q[15:8]}, 32'hC0);
        chk("status mode kept", {31'h0, q[3]}, 32'h1);
        issue(OP_RESUME, 8'h00, 1'b0);
        chk("resumed busy", {31'h0, q[1]}, 32'h0);
        wb(1'b1, REG_CMD, {28'h0, OP_POWER_DOWN});
        for (n = 0; rpn !== 1'b0 && n < 50; n++) @(negedge mclk);
        chk("power-down low", {31'h0, rpn}, 32'h0);
        chk("busy in abort", {31'h0, rb}, 32'h0);
        for (n = 0; rpn === 1'b0 && n < 50; n++) @(negedge mclk);
        chk("power-down width", n, PD_CYC);
        wb(1'b1, REG_ADDR, 32'h00055);
        issue(OP_BUS_READ, 8'h00, 1'b1);
        chk("array after wake", {24'h0, q[15:8]}, 32'h69);
        chk("status mode after wake", {31'h0, q[3]}, 32'h0);
        issue(OP_READ_STATUS, 8'h00, 1'b1);
        issue(OP_BUS_READ, 8'h00, 1'b1);
        chk("status after wake", {24'h0, q[15:8]}, 32'h80);
        // mid-run reset drops the supply requests and config
        wb(1'b1, REG_CONFIG, 32'h3);
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        chk("supply pins after reset", {30'h0, vhh, vpp}, 32'h0);
        wb(1'b0, REG_CONFIG, 32'h0);
        chk("config after reset", q, CONFIG_RESET);
        test_done;
    end
endmodule // flash_bus_mode_and_command_decoder_test
`default_nettype wire
